// >>> led_blink_dimming_regs.sv
// Channel B blink and dimming sequencer with its control registers
`timescale 1ns/1ps

// Operation
// - Reserved register bits read back as zero
// - Fourth phase lasts value times 64 ms
// - Pause lasts value times 64 ms, zero skips
// - Drive high for (code+1)/32 of 8 ms
// - Code zero: high 250 us per period
// - Code all ones: drive high through the whole on phase
// - On-time equals field times 64 ms
// - Ramp select bit enables brightness ramping
// - Four-bit field selects channel C sink current
// - Registers clear to zero on reset
// - First phase lasts value times 64 ms
module led_blink_dimming_regs #(
    parameter int SLOT_CYCLES = led_blink_pkg::SLOT_CYCLES
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // First phase length from the channel's earlier register
    input  wire logic [6:0] led_b_first_phase_length,
    // LED outputs
    output logic            led_b_drive_output,
    output logic      [3:0] led_c_sink_current,
    output logic            led_c_ramp_select
);

    localparam int SLOT_W = (SLOT_CYCLES > 1) ? $clog2(SLOT_CYCLES) : 1;
    localparam logic [SLOT_W-1:0] SLOT_END = SLOT_W'(SLOT_CYCLES - 1);

    if (SLOT_CYCLES < 1) begin : g_bad_slot
        $error("SLOT_CYCLES must be at least one");
    end

    // Register file
    logic [7:0] fourth_r, fourth_nxt;
    logic [7:0] pause_r, pause_nxt;
    logic [7:0] duty_r, duty_nxt;
    logic [7:0] on_dur_r, on_dur_nxt;
    logic [7:0] c_ctrl_r, c_ctrl_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    always_comb begin
        fourth_nxt = fourth_r;
        pause_nxt  = pause_r;
        duty_nxt   = duty_r;
        on_dur_nxt = on_dur_r;
        c_ctrl_nxt = c_ctrl_r;
        rdata_nxt  = rdata_r;
        if (reg_wr) begin
            unique case (reg_addr)
                led_blink_pkg::ADDR_FOURTH_PHASE: begin
                    fourth_nxt = reg_wdata & led_blink_pkg::MASK_PHASE;
                end
                led_blink_pkg::ADDR_PAUSE: begin
                    pause_nxt = reg_wdata & led_blink_pkg::MASK_PHASE;
                end
                led_blink_pkg::ADDR_DUTY: begin
                    duty_nxt = reg_wdata & led_blink_pkg::MASK_DUTY;
                end
                led_blink_pkg::ADDR_ON_DURATION: begin
                    on_dur_nxt = reg_wdata & led_blink_pkg::MASK_ON_DURATION;
                end
                led_blink_pkg::ADDR_C_CONTROL: begin
                    c_ctrl_nxt = reg_wdata & led_blink_pkg::MASK_C_CONTROL;
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                led_blink_pkg::ADDR_FOURTH_PHASE: rdata_nxt = fourth_r;
                led_blink_pkg::ADDR_PAUSE:        rdata_nxt = pause_r;
                led_blink_pkg::ADDR_DUTY:         rdata_nxt = duty_r;
                led_blink_pkg::ADDR_ON_DURATION:  rdata_nxt = on_dur_r;
                led_blink_pkg::ADDR_C_CONTROL:    rdata_nxt = c_ctrl_r;
                default:                          rdata_nxt = led_blink_pkg::READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            fourth_r <= led_blink_pkg::REG_RESET;
            pause_r  <= led_blink_pkg::REG_RESET;
            duty_r   <= led_blink_pkg::REG_RESET;
            on_dur_r <= led_blink_pkg::REG_RESET;
            c_ctrl_r <= led_blink_pkg::REG_RESET;
            rdata_r  <= led_blink_pkg::REG_RESET;
        end else begin
            fourth_r <= fourth_nxt;
            pause_r  <= pause_nxt;
            duty_r   <= duty_nxt;
            on_dur_r <= on_dur_nxt;
            c_ctrl_r <= c_ctrl_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    assign reg_rdata          = rdata_r;
    assign led_c_ramp_select  = c_ctrl_r[led_blink_pkg::RAMP_BIT];
    assign led_c_sink_current = c_ctrl_r[led_blink_pkg::CURRENT_MSB:0];

    // Timebase: 32 slots make the 8 ms period, 8 periods make the 64 ms step
    logic [SLOT_W-1:0] div_r, div_nxt;
    logic [4:0]        slot_r, slot_nxt;
    logic [2:0]        per_r, per_nxt;
    logic              step_tick;

    always_comb begin
        div_nxt   = div_r + SLOT_W'(1);
        slot_nxt  = slot_r;
        per_nxt   = per_r;
        step_tick = 1'b0;
        if (div_r == SLOT_END) begin
            div_nxt  = '0;
            slot_nxt = slot_r + 5'h01;
            if (slot_r == led_blink_pkg::SLOT_LAST) begin
                per_nxt = per_r + 3'h1;
                if (per_r == led_blink_pkg::PERIOD_LAST) begin
                    step_tick = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_r  <= '0;
            slot_r <= 5'h00;
            per_r  <= 3'h0;
        end else begin
            div_r  <= div_nxt;
            slot_r <= slot_nxt;
            per_r  <= per_nxt;
        end
    end

    // Phase sequencer: first, on, fourth, pause, then again
    led_blink_pkg::phase_t phase_r, phase_nxt;
    logic [6:0]            cnt_r, cnt_nxt;
    logic [6:0]            cur_len;
    logic                  drive_r, drive_nxt;
    led_blink_pkg::phase_t next_phase;

    always_comb begin
        unique case (phase_r)
            led_blink_pkg::PH_FIRST: begin
                cur_len    = led_b_first_phase_length;
                next_phase = led_blink_pkg::PH_ON;
            end
            led_blink_pkg::PH_ON: begin
                cur_len    = {2'b00, on_dur_r[led_blink_pkg::DUTY_MSB:0]};
                next_phase = led_blink_pkg::PH_FOURTH;
            end
            led_blink_pkg::PH_FOURTH: begin
                cur_len    = fourth_r[led_blink_pkg::PHASE_MSB:0];
                next_phase = led_blink_pkg::PH_PAUSE;
            end
            led_blink_pkg::PH_PAUSE: begin
                cur_len    = pause_r[led_blink_pkg::PHASE_MSB:0];
                next_phase = led_blink_pkg::PH_FIRST;
            end
        endcase
        phase_nxt = phase_r;
        cnt_nxt   = cnt_r;
        if (cur_len == 7'h00) begin
            phase_nxt = next_phase;
            cnt_nxt   = 7'h00;
        end else if (step_tick) begin
            if (cnt_r + 7'h01 >= cur_len) begin
                phase_nxt = next_phase;
                cnt_nxt   = 7'h00;
            end else begin
                cnt_nxt = cnt_r + 7'h01;
            end
        end
        // High for slots 0..code in the on phase, so code 31 stays high through the whole on phase
        drive_nxt = (phase_nxt == led_blink_pkg::PH_ON)
                    && (slot_nxt <= duty_nxt[led_blink_pkg::DUTY_MSB:0]);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase_r <= led_blink_pkg::PH_FIRST;
            cnt_r   <= 7'h00;
            drive_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            cnt_r   <= cnt_nxt;
            drive_r <= drive_nxt;
        end
    end

    assign led_b_drive_output = drive_r;

    // Check helper: clocks since the last step tick, to time the tick spacing
    localparam int STEP_CYCLES = SLOT_CYCLES * led_blink_pkg::PWM_SLOTS
                                 * led_blink_pkg::PERIODS_PER_STEP;
    logic [31:0] gap_r, gap_nxt;

    always_comb begin
        gap_nxt = gap_r + 32'h1;
        if (step_tick) begin
            gap_nxt = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gap_r <= '0;
        end else begin
            gap_r <= gap_nxt;
        end
    end

    // Checks
    sequence phase_mid_s(led_blink_pkg::phase_t ph);
        phase_r == ph && step_tick && cur_len != 7'h00 && (cnt_r + 7'h01 < cur_len);
    endsequence

    sequence phase_end_s(led_blink_pkg::phase_t ph);
        phase_r == ph && step_tick && cur_len != 7'h00 && (cnt_r + 7'h01 >= cur_len);
    endsequence

    sequence reset_held_s;
        !rstn ##1 !rstn;
    endsequence

    reserved_bit_read_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr == led_blink_pkg::ADDR_DUTY |=> reg_rdata[7:5] == 3'b000)
        else $error("reserved bits read nonzero");
    fourth_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        phase_mid_s(led_blink_pkg::PH_FOURTH) |=> phase_r == led_blink_pkg::PH_FOURTH)
        else $error("fourth phase ended early");
    pause_skip_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        phase_r == led_blink_pkg::PH_PAUSE && pause_r == 8'h00
        |=> phase_r == led_blink_pkg::PH_FIRST)
        else $error("zero pause not skipped");
    duty_low_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        slot_r > duty_r[4:0] |-> !led_b_drive_output)
        else $error("drive high past duty");
    min_duty_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        phase_r == led_blink_pkg::PH_ON && duty_r == 8'h00 && $stable(phase_r)
        |-> led_b_drive_output == (slot_r == 5'h00))
        else $error("minimum duty shape wrong");
    full_duty_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        phase_r == led_blink_pkg::PH_ON && duty_r[4:0] == 5'h1F |-> led_b_drive_output)
        else $error("full duty went low");
    on_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        phase_mid_s(led_blink_pkg::PH_ON) |=> phase_r == led_blink_pkg::PH_ON)
        else $error("on time ended early");
    first_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        phase_mid_s(led_blink_pkg::PH_FIRST) |=> phase_r == led_blink_pkg::PH_FIRST)
        else $error("first phase ended early");
    step_tick_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        step_tick |-> gap_r == 32'(STEP_CYCLES - 1))
        else $error("step tick spacing wrong");
    ramp_bit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr == led_blink_pkg::ADDR_C_CONTROL
        |=> led_c_ramp_select == $past(reg_wdata[led_blink_pkg::RAMP_BIT]))
        else $error("ramp select not stored");
    sink_store_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr == led_blink_pkg::ADDR_C_CONTROL
        |=> led_c_sink_current == $past(reg_wdata[led_blink_pkg::CURRENT_MSB:0]))
        else $error("sink current not stored");
    reserved_bit_store_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (fourth_r & ~led_blink_pkg::MASK_PHASE) == 8'h00
        && (pause_r & ~led_blink_pkg::MASK_PHASE) == 8'h00
        && (duty_r & ~led_blink_pkg::MASK_DUTY) == 8'h00
        && (on_dur_r & ~led_blink_pkg::MASK_ON_DURATION) == 8'h00
        && (c_ctrl_r & ~led_blink_pkg::MASK_C_CONTROL) == 8'h00)
        else $error("reserved register bit set");
    rst_clear_a: assert property (@(posedge sys_clk)
        reset_held_s |-> reg_rdata == led_blink_pkg::REG_RESET && !led_b_drive_output
        && led_c_sink_current == 4'h0 && !led_c_ramp_select)
        else $error("outputs not cleared in reset");
    drive_phase_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        led_b_drive_output |-> phase_r == led_blink_pkg::PH_ON)
        else $error("drive high outside on phase");
    duty_high_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        phase_r == led_blink_pkg::PH_ON && slot_r <= duty_r[led_blink_pkg::DUTY_MSB:0]
        |-> led_b_drive_output)
        else $error("drive low inside duty");
    fourth_end_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        phase_end_s(led_blink_pkg::PH_FOURTH) |=> phase_r == led_blink_pkg::PH_PAUSE)
        else $error("fourth phase overran");
    on_end_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        phase_end_s(led_blink_pkg::PH_ON) |=> phase_r == led_blink_pkg::PH_FOURTH)
        else $error("on time overran");
    first_skip_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        phase_r == led_blink_pkg::PH_FIRST && led_b_first_phase_length == 7'h00
        |=> phase_r == led_blink_pkg::PH_ON)
        else $error("zero first phase not skipped");
    on_skip_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        phase_r == led_blink_pkg::PH_ON && on_dur_r == 8'h00
        |=> phase_r == led_blink_pkg::PH_FOURTH)
        else $error("zero on time not skipped");
    fourth_skip_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        phase_r == led_blink_pkg::PH_FOURTH && fourth_r == 8'h00
        |=> phase_r == led_blink_pkg::PH_PAUSE)
        else $error("zero fourth phase not skipped");

endmodule

// >>> led_blink_pkg.sv
// Constants, register map and phase encoding for the channel B blink sequencer
package led_blink_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_FOURTH_PHASE = 8'h53;
    localparam logic [7:0] ADDR_PAUSE        = 8'h54;
    localparam logic [7:0] ADDR_DUTY         = 8'h55;
    localparam logic [7:0] ADDR_ON_DURATION  = 8'h56;
    localparam logic [7:0] ADDR_C_CONTROL    = 8'h57;

    // Writable bit masks; all other bits are reserved and read as zero
    localparam logic [7:0] MASK_PHASE        = 8'h7F;
    localparam logic [7:0] MASK_DUTY         = 8'h1F;
    localparam logic [7:0] MASK_ON_DURATION  = 8'h1F;
    localparam logic [7:0] MASK_C_CONTROL    = 8'h2F;
    localparam logic [7:0] REG_RESET         = 8'h00;
    localparam logic [7:0] READ_UNMAPPED     = 8'h00;

    // Field positions
    localparam int RAMP_BIT    = 5;
    localparam int CURRENT_MSB = 3;
    localparam int PHASE_MSB   = 6;
    localparam int DUTY_MSB    = 4;

    // Timing
    localparam int CLK_PERIOD_NS    = 40;
    localparam int PWM_PERIOD_MS    = 8;
    localparam int STEP_MS          = 64;
    localparam int PWM_SLOTS        = 32;
    localparam int PWM_PERIOD_NS    = PWM_PERIOD_MS * 1000000;
    localparam int SLOT_CYCLES      = PWM_PERIOD_NS / PWM_SLOTS / CLK_PERIOD_NS;
    localparam int PERIODS_PER_STEP = STEP_MS / PWM_PERIOD_MS;

    localparam logic [4:0] SLOT_LAST   = 5'h1F;
    localparam logic [2:0] PERIOD_LAST = 3'h7;

    // Sequence phases, Gray coded along the loop
    typedef enum logic [1:0] {
        PH_FIRST  = 2'b00,
        PH_ON     = 2'b01,
        PH_FOURTH = 2'b11,
        PH_PAUSE  = 2'b10
    } phase_t;

endpackage

// >>> led_blink_dimming_regs_test.sv
// Self-checking testbench for the channel B blink and dimming sequencer
`timescale 1ns/1ps
module led_blink_dimming_regs_test;
    localparam int SLOTS = 2;
    localparam int STEP  = SLOTS * led_blink_pkg::PWM_SLOTS * led_blink_pkg::PERIODS_PER_STEP;
    logic       sys_clk;
    logic       rstn;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [6:0] first_len;
    logic       drive;
    logic [3:0] sink;
    logic       ramp;
    logic       rd_pend;
    logic [7:0] exp_q[$];
    logic [7:0] shadow;
    logic [4:0] duty;
    logic [7:0] addrs[5] = '{led_blink_pkg::ADDR_FOURTH_PHASE, led_blink_pkg::ADDR_PAUSE,
        led_blink_pkg::ADDR_DUTY, led_blink_pkg::ADDR_ON_DURATION, led_blink_pkg::ADDR_C_CONTROL};
    logic [7:0] masks[5] = '{led_blink_pkg::MASK_PHASE, led_blink_pkg::MASK_PHASE,
        led_blink_pkg::MASK_DUTY, led_blink_pkg::MASK_ON_DURATION, led_blink_pkg::MASK_C_CONTROL};
    int         fails;
    int         num_checks;
    int         seed;
    int         n;

    led_blink_dimming_regs #(.SLOT_CYCLES(SLOTS)) i_led_blink_dimming_regs (
        .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .led_b_first_phase_length(first_len), .led_b_drive_output(drive),
        .led_c_sink_current(sink), .led_c_ramp_select(ramp));

    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        num_checks++;
        if (seen !== want) begin
            fails++;
            $display("[ERR] %0t %s: seen %0h want %0h", $time, what, seen, want);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic wr);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= wr;
        reg_rd    <= !wr;
        if (!wr) exp_q.push_back(d);
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask

    // Counts samples at which the drive keeps level v, at most lim
    task automatic run_len(input logic v, input int lim, output int cnt);
        cnt = 0;
        while (drive === v && cnt < lim) begin
            @(negedge sys_clk);
            cnt++;
        end
    endtask

    task automatic seek(input logic v, input int lim);
        int k;
        run_len(!v, lim, k);
        if (k >= lim) begin
            check(k, 0, "drive level wait timed out");
            complete_run();
        end
    endtask

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 5; i++) access(addrs[i], led_blink_pkg::REG_RESET, 1'b0);
        check(sink, 4'h0, "sink current after reset");
        check(ramp, 1'b0, "ramp select after reset");
        $display("reset test done");
    endtask

    always @(posedge sys_clk) rd_pend <= reg_rd;

    // Read results appear the edge after the read strobe is taken
    always @(negedge sys_clk) begin
        if (rd_pend === 1'b1) begin
            if (exp_q.size() == 0) check(1'b1, 1'b0, "unexpected read");
            else check(reg_rdata, exp_q.pop_front(), "read data");
        end
    end

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        {rstn, reg_addr, reg_wdata, reg_wr, reg_rd, first_len} = '0;
        fails = 0;
        num_checks = 0;
        seed = 34;
        do_reset();
        // Duty sweep inside a long on phase, idle phases zero length
        access(led_blink_pkg::ADDR_ON_DURATION, 8'h1F, 1'b1);
        for (int i = 0; i < 6; i++) begin
            duty = (i == 0) ? 5'h00 : (i == 5) ? 5'h1F : 5'($random(seed)) & 5'h1E;
            access(led_blink_pkg::ADDR_DUTY, {3'h0, duty}, 1'b1);
            @(negedge sys_clk);
            if (duty != 5'h1F) seek(1'b0, 100);
            else repeat (2 * SLOTS * 32) @(negedge sys_clk);
            seek(1'b1, 100);
            run_len(1'b1, SLOTS * 32, n);
            check(n, (duty + 1) * SLOTS, "high time");
            if (duty != 5'h1F) begin
                run_len(1'b0, SLOTS * 32, n);
                check(n, (31 - duty) * SLOTS, "low time");
            end
        end
        $display("duty test done");
        // Phase lengths, with the drive held high through the on phase
        access(led_blink_pkg::ADDR_FOURTH_PHASE, 8'h81, 1'b1);
        first_len <= 7'h02;
        access(led_blink_pkg::ADDR_ON_DURATION, 8'h02, 1'b1);
        @(negedge sys_clk);
        seek(1'b0, 40 * STEP);
        seek(1'b1, 8 * STEP);
        run_len(1'b1, 8 * STEP, n);
        check(n, 2 * STEP, "on time");
        run_len(1'b0, 8 * STEP, n);
        check(n, 3 * STEP, "idle with zero pause");
        access(led_blink_pkg::ADDR_PAUSE, 8'h03, 1'b1);
        @(negedge sys_clk);
        seek(1'b0, 8 * STEP);
        run_len(1'b0, 8 * STEP, n);
        check(n, 6 * STEP, "idle with pause");
        $display("phase test done");
        // Random writes, masked readback, channel C outputs, unmapped place
        for (int j = 0; j < 2; j++) begin
            for (int i = 0; i < 5; i++) begin
                shadow = 8'($random(seed));
                shadow[5] = j[0];
                access(addrs[i], shadow, 1'b1);
                access(addrs[i], shadow & masks[i], 1'b0);
            end
            check(sink, shadow[3:0], "sink current");
            check(ramp, j[0], "ramp select");
        end
        access(8'h60, 8'hFF, 1'b1);
        access(8'h60, led_blink_pkg::READ_UNMAPPED, 1'b0);
        $display("register test done");
        do_reset();
        repeat (3) @(posedge sys_clk);
        complete_run();
    end
endmodule
